/* rtio_consts.svh */
/*
  rtio_consts.svh: timing counts, field positions and reset values of the rtio block.
  assumes a 32.768 kHz oscillator clock that is sampled by the system clock.
*/
`ifndef RTIO_CONSTS_SVH
`define RTIO_CONSTS_SVH

// ============================================================
// oscillator and timing
`define RTIO_OSC_HZ        32768
`define RTIO_SAMPLE_US     15600
`define RTIO_SAMPLE_TICKS  ((`RTIO_SAMPLE_US * `RTIO_OSC_HZ + 999999) / 1000000)
`define RTIO_EDGE_US       7810
`define RTIO_EDGE_TICKS    ((`RTIO_EDGE_US * `RTIO_OSC_HZ + 999999) / 1000000)
`define RTIO_DEFER_MS      500
`define RTIO_DEFER_TICKS   ((`RTIO_DEFER_MS * `RTIO_OSC_HZ) / 1000)
`define RTIO_SEC_WRAP      15'h7FFF
`define RTIO_DIV_16HZ_BIT  10
`define RTIO_DIV_1HZ_BIT   14

// ============================================================
// field positions and limits
`define RTIO_MERIDIEM_BIT  6
`define RTIO_HOUR_MASK     8'h3F
`define RTIO_PM_OFFSET     7'd12
`define RTIO_HALF_MIN      8'h30
`define RTIO_FREQ_1HZ      5'h10

// ============================================================
// reset values of the time fields
`define RTIO_RST_YEAR      8'h00
`define RTIO_RST_MONTH     8'h01
`define RTIO_RST_DAY       8'h01
`define RTIO_RST_WDAY      3'h0
`define RTIO_RST_HOUR      8'h00
`define RTIO_RST_MIN       8'h00
`define RTIO_RST_SEC       8'h00

`endif

/* rtio_core.sv */
/*
  rtio_core.sv: supply-low flag, time write check and calendar, interrupt pin modes.
  assumes host controls come from logic on sys_clk_i; oscillator and comparator are pins.
*/
// Functional notes
// - supply is sampled once per second for a 15.6 ms window only
// - a low sample sets the flag and halts sampling; flag then holds
// - a host read of the flag resumes sampling; good sample clears it
// - year with a digit A to F is written as 00
// - bad month or day values are written as 01
// - weekday 7 becomes 0; bad hour in either mode becomes 00
// - bad minute becomes 00; bad second fixed at next carry, which carries
// - a day beyond the month length becomes the first of next month
// - both pins offer alarm, frequency, edge, periodic one; pin a more
// - alarm mode drives the pin low when weekday, hour, minute match
// - alarm low is released only by clearing the alarm enable
// - re-enabling the alarm during a match does not drive low
// - reprogramming during a match drives low at the next minute carry
// - frequency mode outputs the AND of the selected divider taps
// - edge mode goes low at the first minute carry after selection
// - edge mode stays low until its enable is cleared
// - minute event lasts 7.81 ms; re-enable inside it drives low again
// - periodic one gives a 50 percent one-minute wave from the first carry
// - periodic one disabled forces high; enabled again resumes low
// - periodic two pulses low at each carry; reads defer it up to 0.5 s
// - after power-on the power-on flag is set and pin a outputs 1 Hz until init
`include "rtio_consts.svh"

module rtio_core
  import rtio_pkg::*;
#(
  parameter int DEFER_TICKS = `RTIO_DEFER_TICKS
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // oscillator and supply comparator
  input  wire logic       osc_clk_i,
  input  wire logic       supply_below_i,
  output logic            supply_sample_o,
  // host control
  input  wire logic       init_i,
  input  wire logic       flag_read_i,
  input  wire logic       time_reading_i,
  input  wire logic       hour_24_i,
  input  wire logic       osc_out_enable_i,
  input  wire logic       pin_a_alarm_enable_i,
  input  wire logic       pin_a_minute_edge_enable_i,
  input  wire logic       pin_a_freq_enable_i,
  input  wire logic       pin_b_alarm_enable_i,
  input  wire logic       pin_b_minute_edge_enable_i,
  input  wire logic       pin_b_freq_enable_i,
  // alarm and frequency data
  input  wire logic [2:0] alarm_a_wday_i,
  input  wire logic [7:0] alarm_a_hour_i,
  input  wire logic [7:0] alarm_a_min_i,
  input  wire logic       alarm_a_load_i,
  input  wire logic [4:0] freq_a_sel_i,
  input  wire logic [2:0] alarm_b_wday_i,
  input  wire logic [7:0] alarm_b_hour_i,
  input  wire logic [7:0] alarm_b_min_i,
  input  wire logic       alarm_b_load_i,
  input  wire logic [4:0] freq_b_sel_i,
  // time write
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_year_i,
  input  wire logic [7:0] wr_month_i,
  input  wire logic [7:0] wr_day_i,
  input  wire logic [2:0] wr_wday_i,
  input  wire logic [7:0] wr_hour_i,
  input  wire logic [7:0] wr_min_i,
  input  wire logic [7:0] wr_sec_i,
  // status and time
  output logic            supply_low_flag_o,
  output logic            power_on_flag_o,
  output logic [7:0]      time_year_o,
  output logic [7:0]      time_month_o,
  output logic [7:0]      time_day_o,
  output logic [2:0]      time_wday_o,
  output logic [7:0]      time_hour_o,
  output logic [7:0]      time_min_o,
  output logic [7:0]      time_sec_o,
  // open-drain interrupt pins
  input  wire logic       irq_out_a_i,
  output logic            irq_out_a_o,
  output logic            irq_out_a_oe_o,
  input  wire logic       irq_out_b_i,
  output logic            irq_out_b_o,
  output logic            irq_out_b_oe_o
);

  // ============================================================
  // helpers
  function automatic logic nib_bad(input logic [7:0] v);
    return (v[3:0] > 4'h9) || (v[7:4] > 4'h9);
  endfunction : nib_bad

  function automatic logic [6:0] bcd2bin(input logic [7:0] v);
    return 7'(7'(v[7:4]) * 7'd10) + {3'b000, v[3:0]};
  endfunction : bcd2bin

  function automatic logic [7:0] bin2bcd(input logic [6:0] b);
    logic [6:0] t;
    t = b / 7'd10;
    return {t[3:0], 4'(b - 7'(t * 7'd10))};
  endfunction : bin2bcd

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    logic [6:0] yb;
    yb = bcd2bin(y);
    case (m)
      8'h02:                      month_len = (yb[1:0] == 2'b00) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default:                    month_len = 8'h31;
    endcase
  endfunction : month_len

  function automatic rtio_mode_t pin_mode(input logic ae, input logic me, input logic fe,
                                          input logic osc, input logic two);
    if (osc) begin
      return MODE_OSC;
    end
    case ({fe, me})
      2'b10:   return MODE_FREQ;
      2'b01:   return MODE_EDGE;
      2'b11:   return (two && ae) ? MODE_PER2 : MODE_PER1;
      default: return ae ? MODE_ALARM : MODE_OFF;
    endcase
  endfunction : pin_mode

  // ============================================================
  // pin synchronisers and oscillator divider
  logic [2:0]  osc_sync_ff;
  logic [1:0]  below_sync_ff;
  logic [14:0] div_ff;
  logic        tick;
  logic        sec_tick;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_sync_ff   <= 3'h0;
      below_sync_ff <= 2'h0;
    end else begin
      osc_sync_ff   <= {osc_sync_ff[1:0], osc_clk_i};
      below_sync_ff <= {below_sync_ff[0], supply_below_i};
    end
  end

  assign tick     = osc_sync_ff[1] & ~osc_sync_ff[2];
  assign sec_tick = tick & (div_ff == `RTIO_SEC_WRAP);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= 15'h0000;
    end else if (tick) begin
      div_ff <= div_ff + 15'h0001;
    end
  end

  // ============================================================
  // supply-low monitor
  logic halt_ff;
  logic low_flag_ff;
  logic samp_end;

  assign samp_end = tick & ~halt_ff & (div_ff == 15'(`RTIO_SAMPLE_TICKS - 1));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_sample_o <= 1'b0;
      halt_ff         <= 1'b0;
      low_flag_ff     <= 1'b0;
    end else begin
      supply_sample_o <= ~halt_ff & (div_ff < 15'(`RTIO_SAMPLE_TICKS));
      if (samp_end && below_sync_ff[1]) begin
        low_flag_ff <= 1'b1;
        halt_ff     <= 1'b1;
      end else begin
        if (samp_end) begin
          low_flag_ff <= 1'b0;
        end
        if (flag_read_i) begin
          halt_ff <= 1'b0;
        end
      end
    end
  end

  assign supply_low_flag_o = low_flag_ff;

  // ============================================================
  // write check
  logic [7:0] w_year;
  logic [7:0] w_month;
  logic [7:0] w_day;
  logic [2:0] w_wday;
  logic [7:0] w_hour;
  logic [7:0] w_min;
  logic [7:0] hraw;

  always_comb begin
    hraw    = wr_hour_i & `RTIO_HOUR_MASK;
    w_year  = nib_bad(wr_year_i) ? `RTIO_RST_YEAR : wr_year_i;
    w_month = (nib_bad(wr_month_i) || wr_month_i == 8'h00 || wr_month_i > 8'h12)
              ? `RTIO_RST_MONTH : wr_month_i;
    w_day   = (nib_bad(wr_day_i) || wr_day_i == 8'h00 || wr_day_i > 8'h31)
              ? `RTIO_RST_DAY : wr_day_i;
    w_wday  = (wr_wday_i == 3'd7) ? `RTIO_RST_WDAY : wr_wday_i;
    w_min   = (nib_bad(wr_min_i) || wr_min_i > 8'h59) ? `RTIO_RST_MIN : wr_min_i;
    if (nib_bad(hraw) || (hour_24_i ? (hraw > 8'h23) : (hraw > 8'h11))) begin
      w_hour = `RTIO_RST_HOUR;
    end else if (!hour_24_i && wr_hour_i[`RTIO_MERIDIEM_BIT]) begin
      w_hour = bin2bcd(bcd2bin(hraw) + `RTIO_PM_OFFSET);
    end else begin
      w_hour = hraw;
    end
    if (w_day > month_len(w_month, w_year)) begin
      w_day   = `RTIO_RST_DAY;
      w_month = bcd_inc(w_month);
    end
  end

  // ============================================================
  // second carry with read deferral and calendar
  logic        pend_ff;
  logic [14:0] defer_cnt_ff;
  logic        sec_go;
  logic        min_carry;
  logic        hour_carry;
  logic        day_carry;
  logic        mon_carry;

  assign sec_go     = (sec_tick | pend_ff) &
                      (~time_reading_i | (defer_cnt_ff == 15'(DEFER_TICKS)));
  assign min_carry  = sec_go & (nib_bad(time_sec_o) || time_sec_o >= 8'h59);
  assign hour_carry = min_carry & (time_min_o == 8'h59);
  assign day_carry  = hour_carry & (time_hour_o == 8'h23);
  assign mon_carry  = day_carry & (time_day_o >= month_len(time_month_o, time_year_o));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_ff      <= 1'b0;
      defer_cnt_ff <= 15'h0000;
    end else begin
      if (sec_go) begin
        pend_ff <= 1'b0;
      end else if (sec_tick) begin
        pend_ff <= 1'b1;
      end
      if (!pend_ff) begin
        defer_cnt_ff <= 15'h0000;
      end else if (tick) begin
        defer_cnt_ff <= defer_cnt_ff + 15'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_year_o  <= `RTIO_RST_YEAR;
      time_month_o <= `RTIO_RST_MONTH;
      time_day_o   <= `RTIO_RST_DAY;
      time_wday_o  <= `RTIO_RST_WDAY;
      time_hour_o  <= `RTIO_RST_HOUR;
      time_min_o   <= `RTIO_RST_MIN;
      time_sec_o   <= `RTIO_RST_SEC;
    end else if (init_i) begin
      time_year_o  <= `RTIO_RST_YEAR;
      time_month_o <= `RTIO_RST_MONTH;
      time_day_o   <= `RTIO_RST_DAY;
      time_wday_o  <= `RTIO_RST_WDAY;
      time_hour_o  <= `RTIO_RST_HOUR;
      time_min_o   <= `RTIO_RST_MIN;
      time_sec_o   <= `RTIO_RST_SEC;
    end else if (wr_i) begin
      time_year_o  <= w_year;
      time_month_o <= w_month;
      time_day_o   <= w_day;
      time_wday_o  <= w_wday;
      time_hour_o  <= w_hour;
      time_min_o   <= w_min;
      time_sec_o   <= wr_sec_i;
    end else if (sec_go) begin
      time_sec_o <= min_carry ? `RTIO_RST_SEC : bcd_inc(time_sec_o);
      if (min_carry) begin
        time_min_o <= hour_carry ? `RTIO_RST_MIN : bcd_inc(time_min_o);
      end
      if (hour_carry) begin
        time_hour_o <= day_carry ? `RTIO_RST_HOUR : bcd_inc(time_hour_o);
      end
      if (day_carry) begin
        time_wday_o <= (time_wday_o == 3'd6) ? `RTIO_RST_WDAY : time_wday_o + 3'd1;
        time_day_o  <= mon_carry ? `RTIO_RST_DAY : bcd_inc(time_day_o);
      end
      if (mon_carry) begin
        time_month_o <= (time_month_o == 8'h12) ? `RTIO_RST_MONTH : bcd_inc(time_month_o);
        if (time_month_o == 8'h12) begin
          time_year_o <= (time_year_o == 8'h99) ? `RTIO_RST_YEAR : bcd_inc(time_year_o);
        end
      end
    end
  end

  // ============================================================
  // power-on flag and minute event window
  logic       por_ff;
  logic       win_ff;
  logic [8:0] edge_cnt_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_ff <= 1'b1;
    end else if (init_i) begin
      por_ff <= 1'b0;
    end
  end

  assign power_on_flag_o = por_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_ff      <= 1'b0;
      edge_cnt_ff <= 9'h000;
    end else if (min_carry) begin
      win_ff      <= 1'b1;
      edge_cnt_ff <= 9'h000;
    end else if (win_ff && tick) begin
      edge_cnt_ff <= edge_cnt_ff + 9'h001;
      if (edge_cnt_ff == 9'(`RTIO_EDGE_TICKS - 1)) begin
        win_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // interrupt pins
  logic [1:0] ae;
  logic [1:0] ld;
  logic [4:0] fsel [2];
  logic [2:0] al_wday [2];
  logic [7:0] al_hour [2];
  logic [7:0] al_min [2];
  rtio_mode_t mode [2];
  logic [1:0] match;
  logic [1:0] freq_lvl;
  logic [1:0] drive;
  logic [1:0] match_prev_ff;
  logic [1:0] al_low_ff;
  logic [1:0] rearm_ff;
  logic [1:0] edge_low_ff;
  logic [1:0] per1_run_ff;
  logic [1:0] oe_ff;

  assign ae         = {pin_b_alarm_enable_i, pin_a_alarm_enable_i};
  assign ld         = {alarm_b_load_i, alarm_a_load_i};
  assign fsel[0]    = por_ff ? `RTIO_FREQ_1HZ : freq_a_sel_i;
  assign fsel[1]    = freq_b_sel_i;
  assign al_wday[0] = alarm_a_wday_i;
  assign al_wday[1] = alarm_b_wday_i;
  assign al_hour[0] = alarm_a_hour_i;
  assign al_hour[1] = alarm_b_hour_i;
  assign al_min[0]  = alarm_a_min_i;
  assign al_min[1]  = alarm_b_min_i;
  assign mode[0]    = por_ff ? MODE_FREQ :
                      pin_mode(pin_a_alarm_enable_i, pin_a_minute_edge_enable_i,
                               pin_a_freq_enable_i, osc_out_enable_i, 1'b1);
  assign mode[1]    = pin_mode(pin_b_alarm_enable_i, pin_b_minute_edge_enable_i,
                               pin_b_freq_enable_i, 1'b0, 1'b0);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      match[i]    = (time_wday_o == al_wday[i]) && (time_hour_o == al_hour[i]) &&
                    (time_min_o == al_min[i]);
      freq_lvl[i] = &(div_ff[`RTIO_DIV_1HZ_BIT:`RTIO_DIV_16HZ_BIT] | ~fsel[i]);
      case (mode[i])
        MODE_ALARM: drive[i] = al_low_ff[i];
        MODE_FREQ:  drive[i] = ~freq_lvl[i];
        MODE_EDGE:  drive[i] = edge_low_ff[i];
        MODE_PER1:  drive[i] = per1_run_ff[i] & (time_sec_o < `RTIO_HALF_MIN);
        MODE_PER2:  drive[i] = win_ff;
        MODE_OSC:   drive[i] = ~osc_sync_ff[2];
        default:    drive[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_prev_ff <= 2'b00;
      al_low_ff     <= 2'b00;
      rearm_ff      <= 2'b00;
      edge_low_ff   <= 2'b00;
      per1_run_ff   <= 2'b00;
      oe_ff         <= 2'b00;
    end else begin
      match_prev_ff <= match;
      oe_ff         <= drive;
      for (int i = 0; i < 2; i++) begin
        if (!ae[i]) begin
          al_low_ff[i] <= 1'b0;
        end else if (mode[i] == MODE_ALARM &&
                     ((match[i] && !match_prev_ff[i]) || (rearm_ff[i] && min_carry))) begin
          al_low_ff[i] <= 1'b1;
        end
        if (ld[i] && ae[i] && match[i]) begin
          rearm_ff[i] <= 1'b1;
        end else if (min_carry) begin
          rearm_ff[i] <= 1'b0;
        end
        edge_low_ff[i] <= (mode[i] == MODE_EDGE) & (edge_low_ff[i] | win_ff);
        if (mode[i] == MODE_PER1 && min_carry) begin
          per1_run_ff[i] <= 1'b1;
        end else if (mode[i] != MODE_PER1 && mode[i] != MODE_OFF) begin
          per1_run_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign irq_out_a_o    = 1'b0;
  assign irq_out_b_o    = 1'b0;
  assign irq_out_a_oe_o = oe_ff[0];
  assign irq_out_b_oe_o = oe_ff[1];

  // ============================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_samp_window;
    supply_sample_o |-> (div_ff <= 15'(`RTIO_SAMPLE_TICKS)) && !$past(halt_ff);
  endproperty
  a_samp_window: assert property (p_samp_window) else $error("sample outside window");

  property p_flag_hold;
    (low_flag_ff && halt_ff && !flag_read_i) |=> (low_flag_ff && halt_ff);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("latched flag lost");

  property p_resume;
    (halt_ff && flag_read_i && !samp_end) |=> !halt_ff ##0 !supply_sample_o;
  endproperty
  a_resume: assert property (p_resume) else $error("read did not resume sampling");

  property p_year_fix;
    (wr_i && !init_i && nib_bad(wr_year_i)) |=> (time_year_o == 8'h00);
  endproperty
  a_year_fix: assert property (p_year_fix) else $error("bad year kept");

  property p_month_fix;
    (wr_i && !init_i && wr_month_i == 8'h00) |=> (time_month_o == 8'h01);
  endproperty
  a_month_fix: assert property (p_month_fix) else $error("bad month kept");

  property p_sec_carry;
    (min_carry && !wr_i && !init_i) |=> (time_sec_o == 8'h00) && $changed(time_min_o);
  endproperty
  a_sec_carry: assert property (p_sec_carry) else $error("second carry wrong");

  property p_month_end;
    (wr_i && !init_i && wr_month_i == 8'h02 && wr_day_i == 8'h30 && !nib_bad(wr_year_i))
      |=> (time_day_o == 8'h01) && (time_month_o == 8'h03);
  endproperty
  a_month_end: assert property (p_month_end) else $error("end of month not fixed");

  property p_alarm_hold;
    (mode[1] == MODE_ALARM && al_low_ff[1]) |=> al_low_ff[1] && irq_out_b_oe_o;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm released early");

  property p_edge_redrive;
    (mode[1] == MODE_EDGE && win_ff) |=> edge_low_ff[1];
  endproperty
  a_edge_redrive: assert property (p_edge_redrive) else $error("edge mode not low");

  property p_win_len;
    win_ff |-> (edge_cnt_ff < 9'(`RTIO_EDGE_TICKS));
  endproperty
  a_win_len: assert property (p_win_len) else $error("minute event too long");

  property p_power_on;
    (por_ff && !init_i) |=> (irq_out_a_oe_o == !$past(div_ff[`RTIO_DIV_1HZ_BIT]));
  endproperty
  a_power_on: assert property (p_power_on) else $error("pin a not 1 Hz at power-on");

endmodule : rtio_core

/* rtio_pins_model.sv */
/*
  rtio_pins_model.sv: far side of the rtio pins, pull-ups and supply comparator.
  assumes oe high means the device pulls the pin low.
*/
module rtio_pins_model (
  // pin drive
  input  wire logic oe_a_i,
  input  wire logic oe_b_i,
  input  wire logic low_cmd_i,
  // resolved levels
  output logic      pin_a_o,
  output logic      pin_b_o,
  output logic      supply_below_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // open drain with pull-up
  assign pin_a_o = oe_a_i ? 1'b0 : 1'b1;
  assign pin_b_o = oe_b_i ? 1'b0 : 1'b1;
  // comparator level, high when supply at or below threshold
  assign supply_below_o = low_cmd_i;
endmodule : rtio_pins_model

/* rtio_pkg.sv */
/*
  rtio_pkg.sv: types of the rtio block.
  assumes nothing beyond a SystemVerilog compiler.
*/
// ============================================================
// pin output modes
package rtio_pkg;
  typedef enum logic [2:0] {
    MODE_OFF   = 3'b000,
    MODE_ALARM = 3'b001,
    MODE_FREQ  = 3'b010,
    MODE_EDGE  = 3'b011,
    MODE_PER1  = 3'b100,
    MODE_PER2  = 3'b101,
    MODE_OSC   = 3'b110
  } rtio_mode_t;
endpackage : rtio_pkg

/* tb_top.sv */
/*
  tb_top.sv: self-checking bench of rtio_core.
  assumes 125 MHz system clock and a free 64 ns oscillator input.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtio_pkg::*;
  // ============================================================
  // signals
  logic clk = 0, rst_n = 0, osc = 0, low_cmd = 1, init = 0, frd = 0, h24 = 1, wr = 0, ose = 0;
  logic aae = 0, ame = 0, afe = 0, bae = 0, bme = 0, bfe = 0, trd = 0;
  logic [4:0] fsel_b = 5'h00;
  logic [7:0] y = 8'h00, mo = 8'h01, d = 8'h01, h = 8'h00, mi = 8'h00, s = 8'h00;
  logic [2:0] w = 3'h0;
  logic [7:0] yo, moo, dayo, ho, mio, so;
  logic [2:0] wo;
  logic samp, blow, pin_a, pin_b, oe_a, oe_b, below, pof, od_a, od_b;
  int err_total = 0, check_count = 0;
  always #4 clk = ~clk;
  always #32 osc = ~osc;
  rtio_pins_model far_u (.oe_a_i(oe_a), .oe_b_i(oe_b), .low_cmd_i(low_cmd), .pin_a_o(pin_a),
    .pin_b_o(pin_b), .supply_below_o(below));
  rtio_core #(.DEFER_TICKS(16)) dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .osc_clk_i(osc),
    .supply_below_i(below), .supply_sample_o(samp), .init_i(init), .flag_read_i(frd),
    .time_reading_i(trd), .hour_24_i(h24), .osc_out_enable_i(ose),
    .pin_a_alarm_enable_i(aae), .pin_a_minute_edge_enable_i(ame), .pin_a_freq_enable_i(afe),
    .pin_b_alarm_enable_i(bae), .pin_b_minute_edge_enable_i(bme), .pin_b_freq_enable_i(bfe),
    .alarm_a_wday_i(3'h1), .alarm_a_hour_i(8'h12), .alarm_a_min_i(8'h00), .alarm_a_load_i(init),
    .freq_a_sel_i(fsel_b), .alarm_b_wday_i(w), .alarm_b_hour_i(h), .alarm_b_min_i(mi),
    .alarm_b_load_i(init), .freq_b_sel_i(fsel_b), .wr_i(wr), .wr_year_i(y), .wr_month_i(mo),
    .wr_day_i(d), .wr_wday_i(w), .wr_hour_i(h), .wr_min_i(mi), .wr_sec_i(s),
    .supply_low_flag_o(blow), .power_on_flag_o(pof), .time_year_o(yo), .time_month_o(moo),
    .time_day_o(dayo), .time_wday_o(wo), .time_hour_o(ho), .time_min_o(mio), .time_sec_o(so),
    .irq_out_a_i(pin_a), .irq_out_a_o(od_a), .irq_out_a_oe_o(oe_a), .irq_out_b_i(pin_b),
    .irq_out_b_o(od_b), .irq_out_b_oe_o(oe_b));
  // ============================================================
  // checks and waits
  task automatic end_sim;
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic sig(input int s);
    case (s)
      0: return pin_a;
      1: return pin_b;
      2: return samp;
      default: return blow;
    endcase
  endfunction : sig
  task automatic wait_lvl(input string n, input int s, input logic v, input int bound);
    int k;
    #1;
    for (k = 0; k < bound && sig(s) !== v; k++) begin
      @(posedge clk);
      #1;
    end
    chk(n, {7'h0, v}, {7'h0, sig(s)});
    if (sig(s) !== v) end_sim();
  endtask : wait_lvl
  task automatic put(input logic [7:0] yy, mm, dd, hh, nn, ss, input logic [2:0] ww);
    @(posedge clk);
    y <= yy;
    mo <= mm;
    d <= dd;
    h <= hh;
    mi <= nn;
    s <= ss;
    w <= ww;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : put
  // ============================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("pof", 8'h01, {7'h0, pof});
    chk("month", 8'h01, moo);
    chk("od_val", 8'h00, {6'h0, od_b, od_a});
    wait_lvl("sample", 2, 1'b1, 100);
    wait_lvl("flag", 3, 1'b1, 6000);
    @(posedge clk) low_cmd <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk("halt", 8'h00, {7'h0, samp});
    chk("flag_hold", 8'h01, {7'h0, blow});
    chk("pin_a_1hz", 8'h00, {7'h0, pin_a});
    @(posedge clk) frd <= 1'b1;
    @(posedge clk) frd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("flag_read", 8'h01, {7'h0, blow});
    @(posedge clk) init <= 1'b1;
    @(posedge clk) init <= 1'b0;
    put(8'h3A, 8'h13, 8'h00, 8'h24, 8'h60, 8'h45, 3'h7);
    chk("pof_init", 8'h00, {7'h0, pof});
    chk("year", 8'h00, yo);
    chk("month", 8'h01, moo);
    chk("day", 8'h01, dayo);
    chk("wday", 8'h00, {5'h0, wo});
    chk("hour", 8'h00, ho);
    chk("min", 8'h00, mio);
    chk("sec_raw", 8'h45, so);
    @(posedge clk) h24 <= 1'b0;
    put(8'hA5, 8'h1A, 8'h32, 8'h12, 8'h7B, 8'h00, 3'h6);
    chk("year12", 8'h00, yo);
    chk("month1A", 8'h01, moo);
    chk("day32", 8'h01, dayo);
    chk("hour12", 8'h00, ho);
    chk("min7B", 8'h00, mio);
    chk("wday6", 8'h06, {5'h0, wo});
    put(8'h99, 8'h12, 8'h31, 8'h47, 8'h59, 8'h59, 3'h5);
    chk("hour_pm", 8'h19, ho);
    chk("year99", 8'h99, yo);
    chk("sec59", 8'h59, so);
    @(posedge clk) h24 <= 1'b1;
    put(8'h24, 8'h02, 8'h30, 8'h10, 8'h15, 8'h00, 3'h2);
    chk("eom_month", 8'h03, moo);
    chk("eom_day", 8'h01, dayo);
    @(posedge clk) bae <= 1'b1;
    put(8'h24, 8'h03, 8'h01, 8'h11, 8'h20, 8'h00, 3'h3);
    wait_lvl("alarm_lo", 1, 1'b0, 8);
    repeat (20) @(posedge clk);
    #1;
    chk("alarm_hold", 8'h00, {7'h0, pin_b});
    @(posedge clk) bae <= 1'b0;
    wait_lvl("alarm_off", 1, 1'b1, 8);
    @(posedge clk) bae <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("alarm_reenable", 8'h01, {7'h0, pin_b});
    @(posedge clk) ose <= 1'b1;
    trd <= 1'b1;
    wait_lvl("osc_lo", 0, 1'b0, 200);
    wait_lvl("osc_hi", 0, 1'b1, 200);
    @(posedge clk) ose <= 1'b0;
    trd <= 1'b0;
    ame <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("edge_wait", 8'h01, {7'h0, pin_a});
    @(posedge clk) bae <= 1'b0;
    bfe <= 1'b1;
    fsel_b <= 5'h01;
    wait_lvl("freq_lo", 1, 1'b0, 20000);
    wait_lvl("freq_hi", 1, 1'b1, 20000);
    wait_lvl("freq_lo2", 1, 1'b0, 20000);
    @(posedge clk) fsel_b <= 5'h00;
    wait_lvl("freq_none", 1, 1'b1, 8);
    @(posedge clk) bfe <= 1'b0;
    end_sim();
  end
endmodule : tb_top
